// ===== can_filter_pkg.sv
// Package with register map, field layout, limits and carrier types of the CAN filter block.
package can_filter_pkg;

   // Register byte addresses on the APB slave.
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_MCTL2  = 8'h04;
   localparam logic [7:0] OFF_BTA    = 8'h08;
   localparam logic [7:0] OFF_BTB    = 8'h0C;
   localparam logic [7:0] OFF_AFC    = 8'h10;
   localparam logic [7:0] OFF_PAT    = 8'h14;
   localparam logic [7:0] OFF_MASK   = 8'h18;
   localparam logic [7:0] OFF_RXFLG  = 8'h1C;
   localparam logic [7:0] OFF_RXEN   = 8'h20;
   localparam logic [7:0] OFF_TXFLG  = 8'h24;
   localparam logic [7:0] OFF_TXEN   = 8'h28;
   localparam logic [7:0] OFF_ERRCNT = 8'h2C;

   // Bit positions in the receive flag and receive enable registers.
   localparam int FLG_RXF  = 0;
   localparam int FLG_OVR  = 1;
   localparam int FLG_BOFF = 2;
   localparam int FLG_TERR = 3;
   localparam int FLG_RERR = 4;
   localparam int FLG_TWRN = 5;
   localparam int FLG_RWRN = 6;
   localparam int FLG_WUP  = 7;

   // Field positions in the acceptance control and error count registers.
   localparam int AFC_HIT_LSB = 4;
   localparam int ERR_TX_LSB  = 8;

   // Error counter limits.
   localparam logic [8:0] WARN_LIMIT    = 9'h060;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
   localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;

   // Care vectors of the filter compare word.
   localparam logic [31:0] CARE_ALL  = 32'hFFFF_FFFF;
   localparam logic [31:0] CARE_STD  = 32'hFFF8_0000;
   localparam logic [31:0] CARE_HALF = 32'hFFFF_0000;
   localparam logic [31:0] CARE_BYTE = 32'hFF00_0000;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_DUAL   = 2'h1,
      MODE_QUAD   = 2'h2,
      MODE_CLOSED = 2'h3
   } filter_mode_t;

   // A received frame, presented for one cycle right after its end of frame.
   typedef struct packed {
      logic        valid;
      logic        ide;
      logic        rtr;
      logic        srr;
      logic [28:0] id;
   } rx_frame_t;

   // Locked configuration handed to the frame engine.
   typedef struct packed {
      logic [7:0] module_control_two;
      logic [7:0] bit_timing_a;
      logic [7:0] bit_timing_b;
   } config_t;

endpackage

// ===== can_filter_irq_protect.sv
// Acceptance filter, interrupt flags and configuration lock of a CAN controller with an APB slave.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module can_filter_irq_protect #(
   parameter int NUM_TX_BUF = 3
) (
   input  wire logic                      i_clock,
   input  wire logic                      i_reset,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire can_filter_pkg::rx_frame_t i_rx_frame,
   input  wire logic [7:0]                i_rx_err_count,
   input  wire logic [8:0]                i_tx_err_count,
   input  wire logic [NUM_TX_BUF-1:0]     i_tx_empty,
   input  wire logic                      i_sleep_ack,
   input  wire logic                      i_power_down,
   input  wire logic                      i_can_rx,
   input  wire logic                      i_tx_bit,
   output logic                           o_can_tx,
   output logic                           o_bus_halt,
   output logic                           o_copy_to_foreground,
   output can_filter_pkg::config_t        o_config,
   output logic                           o_irq_wakeup,
   output logic                           o_irq_error,
   output logic                           o_irq_receive,
   output logic                           o_irq_transmit
);

   typedef struct packed {
      logic                         soft_reset;
      can_filter_pkg::config_t      cfg;
      can_filter_pkg::filter_mode_t mode;
      logic [31:0]                  pattern;
      logic [31:0]                  mask;
      logic [7:0]                   flags;
      logic [7:0]                   rx_en;
      logic [NUM_TX_BUF-1:0]        tx_en;
      logic [1:0]                   hit;
      logic                         bg_full;
      logic [1:0]                   bg_hit;
      logic                         copy_pulse;
      logic [1:0]                   rx_sync;
      logic [31:0]                  rdata;
      logic                         slverr;
   } state_t;

   state_t st;
   state_t next_st;

   // Builds the 32-bit compare word in the layout of the pattern bank.
   function automatic logic [31:0] compare_word(input can_filter_pkg::rx_frame_t f);
      if (f.ide)
         compare_word = {f.id[28:18], f.srr, f.ide, f.id[17:0], f.rtr};
      else
         compare_word = {f.id[10:0], f.rtr, f.ide, 19'h0_0000};
   endfunction

   // A set mask bit makes its position match whatever was received.
   function automatic logic field_match(input logic [31:0] w, input logic [31:0] pat,
                                        input logic [31:0] msk, input logic [31:0] care);
      field_match = ~|((w ^ pat) & ~msk & care);
   endfunction

   // Lowest-numbered hit takes the index.
   function automatic logic [1:0] lowest_hit(input logic [3:0] h);
      if (h[0])
         lowest_hit = 2'h0;
      else if (h[1])
         lowest_hit = 2'h1;
      else if (h[2])
         lowest_hit = 2'h2;
      else
         lowest_hit = 2'h3;
   endfunction

   logic [31:0] word;
   logic [31:0] std_care;
   logic [3:0]  dual_hit;
   logic [3:0]  quad_hit;
   logic [3:0]  hits;
   logic        low_power;
   logic        fire;
   logic        wr;
   logic        rd_setup;

   assign word      = compare_word(i_rx_frame);
   assign std_care  = i_rx_frame.ide ? can_filter_pkg::CARE_ALL : can_filter_pkg::CARE_STD;
   assign low_power = i_sleep_ack | i_power_down | st.soft_reset;
   assign wr        = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable;

   // Each section's pattern and mask slice is shifted up to meet the identifier head.
   generate
      for (genvar k = 0; k < 4; k++)
      begin : g_section
         assign dual_hit[k] = field_match(word, st.pattern << (16 * (k % 2)), st.mask << (16 * (k % 2)),
                                          can_filter_pkg::CARE_HALF & std_care);
         assign quad_hit[k] = field_match(word, st.pattern << (8 * k), st.mask << (8 * k),
                                          can_filter_pkg::CARE_BYTE);
      end
   endgenerate

   // Mode field picks which hit vector counts; closed mode yields none.
   always_comb
   begin
      unique case (st.mode)
         can_filter_pkg::MODE_SINGLE: hits = {3'h0, field_match(word, st.pattern, st.mask, std_care)};
         can_filter_pkg::MODE_DUAL:   hits = {2'h0, dual_hit[1:0]};
         can_filter_pkg::MODE_QUAD:   hits = quad_hit;
         can_filter_pkg::MODE_CLOSED: hits = 4'h0;
      endcase
   end

   // Frames are dropped while halted or asleep, since the engine is not listening then.
   assign fire = i_rx_frame.valid & ~low_power & (|hits);

   // Register read mux; error counters appear here and nowhere as a write target.
   function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a,
                                            input logic [NUM_TX_BUF-1:0] tx_empty_flag,
                                            input logic [7:0] rxc, input logic [8:0] txc);
      read_reg = 32'h0000_0000;
      unique case (a)
         can_filter_pkg::OFF_CTRL:   read_reg[0] = s.soft_reset;
         can_filter_pkg::OFF_MCTL2:  read_reg[7:0] = s.cfg.module_control_two;
         can_filter_pkg::OFF_BTA:    read_reg[7:0] = s.cfg.bit_timing_a;
         can_filter_pkg::OFF_BTB:    read_reg[7:0] = s.cfg.bit_timing_b;
         can_filter_pkg::OFF_AFC:    read_reg[can_filter_pkg::AFC_HIT_LSB + 1:0] = {s.hit, 2'h0, s.mode};
         can_filter_pkg::OFF_PAT:    read_reg = s.pattern;
         can_filter_pkg::OFF_MASK:   read_reg = s.mask;
         can_filter_pkg::OFF_RXFLG:  read_reg[7:0] = s.flags;
         can_filter_pkg::OFF_RXEN:   read_reg[7:0] = s.rx_en;
         can_filter_pkg::OFF_TXFLG:  read_reg[NUM_TX_BUF-1:0] = tx_empty_flag;
         can_filter_pkg::OFF_TXEN:   read_reg[NUM_TX_BUF-1:0] = s.tx_en;
         can_filter_pkg::OFF_ERRCNT: read_reg[can_filter_pkg::ERR_TX_LSB + 8:0] = {txc, rxc};
         default:                    read_reg = 32'h0000_0000;
      endcase
   endfunction

   // Only aligned words up to the error count register answer without an error.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= can_filter_pkg::OFF_ERRCNT);
   endfunction

   // Next-state logic: register writes, flag set and clear, receive buffer hand-over.
   always_comb
   begin
      logic [7:0] clr;
      logic [7:0] cond;
      logic       fg_busy;
      logic       unlocked;
      clr      = 8'h00;
      cond     = 8'h00;
      next_st  = st;
      unlocked = st.soft_reset;
      fg_busy  = 1'b0;
      next_st.copy_pulse = 1'b0;
      next_st.rx_sync    = {st.rx_sync[0], i_can_rx};

      // Read data and error answer are caught in the setup phase so they come from flops.
      if (rd_setup)
      begin
         next_st.rdata  = read_reg(st, paddr, i_tx_empty, i_rx_err_count, i_tx_err_count);
         next_st.slverr = ~mapped(paddr);
      end

      // Writes; configuration is frozen unless soft reset is set.
      if (wr)
      begin
         unique case (paddr)
            can_filter_pkg::OFF_CTRL:  next_st.soft_reset = pwdata[0];
            can_filter_pkg::OFF_MCTL2: if (unlocked) next_st.cfg.module_control_two = pwdata[7:0];
            can_filter_pkg::OFF_BTA:   if (unlocked) next_st.cfg.bit_timing_a = pwdata[7:0];
            can_filter_pkg::OFF_BTB:   if (unlocked) next_st.cfg.bit_timing_b = pwdata[7:0];
            can_filter_pkg::OFF_AFC:   if (unlocked) next_st.mode = can_filter_pkg::filter_mode_t'(pwdata[1:0]);
            can_filter_pkg::OFF_PAT:   if (unlocked) next_st.pattern = pwdata;
            can_filter_pkg::OFF_MASK:  if (unlocked) next_st.mask = pwdata;
            can_filter_pkg::OFF_RXFLG: clr = pwdata[7:0];
            can_filter_pkg::OFF_RXEN:  next_st.rx_en = pwdata[7:0];
            can_filter_pkg::OFF_TXEN:  next_st.tx_en = pwdata[NUM_TX_BUF-1:0];
            default:                   clr = 8'h00;
         endcase
      end

      // Level conditions from the error counters; while they hold a clear cannot win.
      cond[can_filter_pkg::FLG_RWRN] = {1'b0, i_rx_err_count} >= can_filter_pkg::WARN_LIMIT;
      cond[can_filter_pkg::FLG_TWRN] = i_tx_err_count >= can_filter_pkg::WARN_LIMIT;
      cond[can_filter_pkg::FLG_RERR] = {1'b0, i_rx_err_count} > can_filter_pkg::PASSIVE_LIMIT;
      cond[can_filter_pkg::FLG_TERR] = i_tx_err_count > can_filter_pkg::PASSIVE_LIMIT;
      cond[can_filter_pkg::FLG_BOFF] = i_tx_err_count > can_filter_pkg::BUS_OFF_LIMIT;
      // Dominant level on the synchronised receive line counts as bus activity.
      cond[can_filter_pkg::FLG_WUP]  = ~st.rx_sync[1] & i_sleep_ack & st.rx_en[can_filter_pkg::FLG_WUP];
      next_st.flags = (st.flags & ~clr) | cond;

      // Foreground release lets a waiting background message move up, except in sleep.
      fg_busy = next_st.flags[can_filter_pkg::FLG_RXF];
      if (!fg_busy && st.bg_full && !i_sleep_ack)
      begin
         next_st.flags[can_filter_pkg::FLG_RXF] = 1'b1;
         next_st.hit        = st.bg_hit;
         next_st.bg_full    = 1'b0;
         next_st.copy_pulse = 1'b1;
         fg_busy            = 1'b1;
      end

      // Accepted frame: straight to the foreground, else background, else lost.
      if (fire)
      begin
         if (!fg_busy)
         begin
            next_st.flags[can_filter_pkg::FLG_RXF] = 1'b1;
            next_st.hit        = lowest_hit(hits);
            next_st.copy_pulse = 1'b1;
         end
         else if (!next_st.bg_full)
         begin
            next_st.bg_full = 1'b1;
            next_st.bg_hit  = lowest_hit(hits);
         end
         else
            next_st.flags[can_filter_pkg::FLG_OVR] = 1'b1;
      end
   end

   // State register; soft reset starts set so the block boots configurable.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         st            <= '0;
         st.soft_reset <= 1'b1;
         // The synchroniser starts recessive so that reset is not taken for bus activity.
         st.rx_sync    <= 2'h3;
      end
      else
         st <= next_st;
   end

   // APB answer: zero wait states, read data registered in the setup phase.
   assign pready  = 1'b1;
   assign prdata  = st.rdata;
   assign pslverr = st.slverr & psel & penable;

   // Outputs toward the frame engine and the transceiver.
   assign o_can_tx             = low_power | i_tx_bit;
   assign o_bus_halt           = st.soft_reset;
   assign o_copy_to_foreground = st.copy_pulse;
   assign o_config             = st.cfg;

   // Interrupt lines are plain flag-and-enable products, so they follow the flags directly.
   assign o_irq_wakeup   = st.flags[can_filter_pkg::FLG_WUP] & st.rx_en[can_filter_pkg::FLG_WUP];
   assign o_irq_error    = |(st.flags[6:1] & st.rx_en[6:1]);
   assign o_irq_receive  = st.flags[can_filter_pkg::FLG_RXF] & st.rx_en[can_filter_pkg::FLG_RXF];
   assign o_irq_transmit = |(i_tx_empty & st.tx_en);

   // Checks on the behaviour above.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_closed_no_fill: assert property ((st.mode == can_filter_pkg::MODE_CLOSED) && i_rx_frame.valid && !st.bg_full
      |=> !st.copy_pulse) else $error("closed filter filled the foreground buffer");
   a_lock_pattern: assert property (wr && (paddr == can_filter_pkg::OFF_PAT) && !st.soft_reset
      |=> $stable(st.pattern)) else $error("pattern changed while locked");
   a_hit_lowest: assert property (fire && !st.flags[can_filter_pkg::FLG_RXF] && !st.bg_full && hits[0]
      |=> st.hit == 2'h0) else $error("hit index not lowest section");
   a_warn_sticks: assert property ({1'b0, i_rx_err_count} >= can_filter_pkg::WARN_LIMIT
      |=> st.flags[can_filter_pkg::FLG_RWRN]) else $error("warning flag cleared while count high");
   a_w1c_clear: assert property (wr && (paddr == can_filter_pkg::OFF_RXFLG) && pwdata[can_filter_pkg::FLG_OVR]
      && !fire |=> !st.flags[can_filter_pkg::FLG_OVR]) else $error("overrun flag not cleared by write");
   a_overrun_set: assert property (fire && st.flags[can_filter_pkg::FLG_RXF] && st.bg_full
      && !(wr && (paddr == can_filter_pkg::OFF_RXFLG) && pwdata[can_filter_pkg::FLG_RXF])
      |=> st.flags[can_filter_pkg::FLG_OVR] && st.bg_full) else $error("third message not flagged overrun");
   a_bus_off: assert property (i_tx_err_count > can_filter_pkg::BUS_OFF_LIMIT
      |=> st.flags[can_filter_pkg::FLG_BOFF] && (!st.rx_en[can_filter_pkg::FLG_BOFF] || o_irq_error))
      else $error("bus-off flag missing");
   a_tx_recessive: assert property ((i_sleep_ack || i_power_down) |-> o_can_tx)
      else $error("transmit pin not recessive in low power");
   a_wake_cause: assert property ($rose(st.flags[can_filter_pkg::FLG_WUP])
      |-> $past(i_sleep_ack) && $past(st.rx_en[can_filter_pkg::FLG_WUP])) else $error("wakeup flag without enable");
   a_rx_irq: assert property (fire && !st.flags[can_filter_pkg::FLG_RXF] && !st.bg_full
      && st.rx_en[can_filter_pkg::FLG_RXF] |=> o_irq_receive && o_copy_to_foreground)
      else $error("receive interrupt late");

   // Counter limits, the lock and the receive hand-over, checked one edge after the cause.
   a_tx_warn: assert property (i_tx_err_count >= can_filter_pkg::WARN_LIMIT
      |=> st.flags[can_filter_pkg::FLG_TWRN]) else $error("transmit warning flag missing");
   a_tx_passive: assert property (i_tx_err_count > can_filter_pkg::PASSIVE_LIMIT
      |=> st.flags[can_filter_pkg::FLG_TERR]) else $error("transmit passive flag missing");
   a_rx_passive: assert property ({1'b0, i_rx_err_count} > can_filter_pkg::PASSIVE_LIMIT
      |=> st.flags[can_filter_pkg::FLG_RERR]) else $error("receive passive flag missing");
   a_lock_timing: assert property (wr && (paddr == can_filter_pkg::OFF_BTA) && !st.soft_reset
      |=> $stable(st.cfg.bit_timing_a)) else $error("bit timing changed while locked");
   a_lock_mode: assert property (wr && (paddr == can_filter_pkg::OFF_AFC) && !st.soft_reset
      |=> $stable(st.mode)) else $error("filter mode changed while locked");
   a_sleep_no_copy: assert property (i_sleep_ack |=> !st.copy_pulse)
      else $error("copy to foreground during sleep");
   a_bg_waits: assert property (st.flags[can_filter_pkg::FLG_RXF] && st.bg_full && !wr
      |=> st.bg_full) else $error("background message moved while foreground full");

   // Main scenarios that the bench is expected to reach.
   c_overrun:  cover property (fire && st.bg_full && st.flags[can_filter_pkg::FLG_RXF]);
   c_quad_hit: cover property (fire && (st.mode == can_filter_pkg::MODE_QUAD) && hits == 4'h8);
   c_dual_hit: cover property (fire && (st.mode == can_filter_pkg::MODE_DUAL) && hits == 4'h2);
   c_bg_copy:  cover property (st.bg_full ##1 !st.bg_full && st.copy_pulse);
   c_wakeup:   cover property ($rose(o_irq_wakeup));

endmodule

`default_nettype wire

// ===== can_filter_pkg_end.sv
// Intentionally empty companion file of the package.

// ===== can_bus_model.sv
// Stand-in for the frame engine and transceiver that feed the filter block.
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
   input  wire logic                 i_clock,
   output can_filter_pkg::rx_frame_t o_rx_frame,
   output logic [7:0]                o_rx_err,
   output logic [8:0]                o_tx_err,
   output logic [2:0]                o_tx_empty,
   output logic                      o_can_rx
);
   // The line idles recessive, the counters start clear and every transmit buffer holds a message.
   initial
   begin
      o_rx_frame = '0;
      {o_rx_err, o_tx_err, o_tx_empty, o_can_rx} = 21'h00_0001;
   end
   // An extended frame shows for one cycle; its fields are then inverted so that a stale copy cannot match.
   task automatic frame(input logic [28:0] id);
      @(posedge i_clock);
      o_rx_frame <= {4'b1101, id};
      @(posedge i_clock);
      o_rx_frame <= {4'b0010, ~id};
   endtask
   // Error counter levels as the protocol engine reports them.
   task automatic counts(input logic [7:0] r, input logic [8:0] t);
      @(posedge i_clock);
      o_rx_err <= r;
      o_tx_err <= t;
   endtask
   task automatic empties(input logic [2:0] e);
      @(posedge i_clock);
      o_tx_empty <= e;
   endtask
   // A short dominant burst stands for bus activity while the controller sleeps.
   task automatic wake;
      @(posedge i_clock);
      o_can_rx <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_can_rx <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== can_filter_irq_protect_tb.sv
// Self-checking bench of the CAN acceptance filter, interrupt flags and configuration lock.
`timescale 1ns/1ps
`default_nettype none
module can_filter_irq_protect_tb;
   localparam logic [28:0] FID = 29'h1ABC_DEF5;
   logic i_clock, i_reset, psel, penable, pwrite, i_sleep_ack, i_power_down, i_tx_bit, err;
   logic pready, pslverr, can_rx, can_tx, halt, copy, irq_w, irq_e, irq_r, irq_t;
   logic [7:0] paddr, rx_err;
   logic [8:0] tx_err;
   logic [2:0] tx_empty;
   logic [31:0] pwdata, prdata, rd_data;
   can_filter_pkg::rx_frame_t frame;
   can_filter_pkg::config_t cfg;
   int n_mismatch, checks_done;

   // Block under test; frames, error counts, empty flags and the receive line come from the bus model.
   can_filter_irq_protect #(.NUM_TX_BUF(3)) dut (
      .i_clock(i_clock), .i_reset(i_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .i_rx_frame(frame), .i_rx_err_count(rx_err), .i_tx_err_count(tx_err), .i_tx_empty(tx_empty),
      .i_sleep_ack(i_sleep_ack), .i_power_down(i_power_down), .i_can_rx(can_rx), .i_tx_bit(i_tx_bit),
      .o_can_tx(can_tx), .o_bus_halt(halt), .o_copy_to_foreground(copy), .o_config(cfg),
      .o_irq_wakeup(irq_w), .o_irq_error(irq_e), .o_irq_receive(irq_r), .o_irq_transmit(irq_t));
   can_bus_model bus (.i_clock(i_clock), .o_rx_frame(frame), .o_rx_err(rx_err), .o_tx_err(tx_err),
      .o_tx_empty(tx_empty), .o_can_rx(can_rx));

   initial
   begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   task automatic conclude;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask

   // One APB transfer; a slave that never answers ends the run.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      k = 0;
      @(posedge i_clock);
      while (pready !== 1'b1 && k < 16)
      begin
         k++;
         @(posedge i_clock);
      end
      chk("pready", 32'h1, 32'(pready));
      if (k == 16)
         conclude();
      else
      begin
         rd_data = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd_data);
   endtask

   // Filter setup only lands while the lock is open, so open and close it around the writes.
   task automatic try_f(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k, input logic a,
                        input logic [1:0] h);
      wr(8'h00, 32'h1);
      wr(8'h10, 32'(m));
      wr(8'h14, p);
      wr(8'h18, k);
      wr(8'h00, 32'h0);
      bus.frame(FID);
      @(negedge i_clock);
      chk("copy", 32'(a), 32'(copy));
      chk("rx irq", 32'(a), 32'(irq_r));
      apb(1'b0, 8'h10, 32'h0);
      if (a)
         chk("hit", 32'(h), 32'(rd_data[5:4]));
      rd("rx full", 8'h1C, 32'(a));
      wr(8'h1C, 32'h1);
   endtask

   task automatic t_lock;
      rd("ctrl", 8'h00, 32'h1);
      chk("halt", 32'h1, 32'(halt));
      chk("tx pin", 32'h1, 32'(can_tx));
      wr(8'h08, 32'h5A);
      wr(8'h0C, 32'h3C);
      wr(8'h04, 32'h11);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'hA5);
      wr(8'h10, 32'h3);
      wr(8'h14, 32'h1);
      @(negedge i_clock);
      chk("timing", 32'h5A, 32'(cfg.bit_timing_a));
      chk("timing b", 32'h3C, 32'(cfg.bit_timing_b));
      chk("control two", 32'h11, 32'(cfg.module_control_two));
      chk("halt", 32'h0, 32'(halt));
      rd("mode", 8'h10, 32'h0);
      rd("pattern", 8'h14, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(err));
   endtask

   // Modes are 0 single, 1 dual, 2 quad, 3 closed.
   task automatic t_filter;
      logic [31:0] w;
      logic [7:0] b;
      w = {FID[28:18], 2'b11, FID[17:0], 1'b0};
      b = w[31:24];
      wr(8'h20, 32'h1);
      try_f(2'h0, w, 32'h0, 1'b1, 2'h0);
      try_f(2'h0, w ^ 32'h20, 32'h0, 1'b0, 2'h0);
      try_f(2'h0, w ^ 32'h20, 32'h20, 1'b1, 2'h0);
      try_f(2'h1, {~w[31:16], w[31:16]}, 32'h0, 1'b1, 2'h1);
      try_f(2'h1, {w[31:16], w[31:16]}, 32'h0, 1'b1, 2'h0);
      try_f(2'h2, {~b, ~b, b, b}, 32'h0, 1'b1, 2'h2);
      try_f(2'h2, {~b, ~b, ~b, b}, 32'h0, 1'b1, 2'h3);
      try_f(2'h3, w, 32'hFFFF_FFFF, 1'b0, 2'h0);
   endtask

   // Closed mode is left in place; reopen the filter to accept everything, then overfill.
   task automatic t_overrun;
      try_f(2'h0, 32'h0, 32'hFFFF_FFFF, 1'b1, 2'h0);
      wr(8'h20, 32'h3);
      bus.frame(FID);
      bus.frame(FID);
      @(negedge i_clock);
      chk("held copy", 32'h0, 32'(copy));
      bus.frame(FID);
      rd("overrun", 8'h1C, 32'h3);
      chk("err irq", 32'h1, 32'(irq_e));
      wr(8'h1C, 32'h1);
      @(negedge i_clock);
      chk("late copy", 32'h1, 32'(copy));
      rd("refill", 8'h1C, 32'h3);
      wr(8'h1C, 32'h3);
      rd("drained", 8'h1C, 32'h0);
      chk("err irq", 32'h0, 32'(irq_e));
   endtask

   task automatic t_errors;
      wr(8'h20, 32'h7C);
      bus.counts(8'h5F, 9'h05F);
      rd("below", 8'h1C, 32'h0);
      bus.counts(8'h60, 9'h060);
      rd("warn", 8'h1C, 32'h60);
      bus.counts(8'h7F, 9'h0FF);
      rd("passive", 8'h1C, 32'h68);
      bus.counts(8'h80, 9'h100);
      rd("bus off", 8'h1C, 32'h7C);
      wr(8'h1C, 32'h7C);
      rd("held", 8'h1C, 32'h7C);
      wr(8'h2C, 32'h0);
      rd("counts", 8'h2C, 32'h0001_0080);
      chk("err irq", 32'h1, 32'(irq_e));
      wr(8'h20, 32'h0);
      @(negedge i_clock);
      chk("masked", 32'h0, 32'(irq_e));
      bus.counts(8'h00, 9'h000);
      wr(8'h1C, 32'h7C);
      rd("cleared", 8'h1C, 32'h0);
   endtask

   task automatic t_tx;
      wr(8'h28, 32'h2);
      chk("tx irq", 32'h0, 32'(irq_t));
      bus.empties(3'b010);
      @(negedge i_clock);
      chk("tx irq", 32'h1, 32'(irq_t));
      bus.empties(3'b101);
      rd("empties", 8'h24, 32'h5);
      chk("tx irq", 32'h0, 32'(irq_t));
      wr(8'h28, 32'h7);
      @(negedge i_clock);
      chk("tx irq", 32'h1, 32'(irq_t));
   endtask

   // Wakeup needs both the sleep handshake and its enable.
   task automatic t_wake;
      @(posedge i_clock);
      i_sleep_ack <= 1'b1;
      bus.wake();
      rd("no enable", 8'h1C, 32'h0);
      chk("sleep pin", 32'h1, 32'(can_tx));
      wr(8'h20, 32'h80);
      i_sleep_ack <= 1'b0;
      bus.wake();
      rd("no ack", 8'h1C, 32'h0);
      i_sleep_ack <= 1'b1;
      bus.wake();
      rd("wakeup", 8'h1C, 32'h80);
      chk("wake irq", 32'h1, 32'(irq_w));
      wr(8'h1C, 32'h80);
      i_sleep_ack <= 1'b0;
      i_power_down <= 1'b1;
      rd("woken", 8'h1C, 32'h0);
      chk("down pin", 32'h1, 32'(can_tx));
      i_power_down <= 1'b0;
      @(negedge i_clock);
      chk("run pin", 32'h0, 32'(can_tx));
      @(posedge i_clock);
      i_tx_bit <= 1'b1;
      @(negedge i_clock);
      chk("tx bit", 32'h1, 32'(can_tx));
   endtask

   initial
   begin
      {i_reset, psel, penable, pwrite, i_sleep_ack, i_power_down, i_tx_bit} = 7'h40;
      {paddr, pwdata} = 40'h00_0000_0000;
      n_mismatch = 0;
      checks_done = 0;
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      t_lock();
      t_filter();
      t_overrun();
      t_errors();
      t_tx();
      t_wake();
      conclude();
   end
endmodule
`default_nettype wire
